// File: src/usbsr_pkg.sv
// Constants and register layout of the USB suspend/resume control block
package usbsr_pkg;
  // Clock and timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int SUSPEND_MS      = 3;
  localparam int SUSPEND_CYC     = SUSPEND_MS * (CLK_HZ / 1000);
  localparam int REMOTE_MIN_MS   = 5;
  localparam int REMOTE_MIN_CYC  = REMOTE_MIN_MS * (CLK_HZ / 1000);
  localparam int RESUME_MS       = 10;
  localparam int RESUME_CYC      = RESUME_MS * (CLK_HZ / 1000);
  localparam int FS_BIT_HZ       = 12_000_000;
  localparam int BUS_RESET_BITS  = 32;
  localparam int BUS_RESET_CYC   = (BUS_RESET_BITS * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ;
  localparam int CNT_W           = 20;
  localparam int SE0_W           = 8;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL  = 12'h0BC;
  localparam logic [11:0] ADDR_FLAGS = 12'h0C0;
  localparam logic [11:0] ADDR_IEN   = 12'h0C4;
  localparam logic [11:0] ADDR_PRIO  = 12'h0C8;
  localparam logic [11:0] ADDR_EPF   = 12'h0CC;
  localparam logic [11:0] ADDR_EPIEN = 12'h0D0;

  // usb_global_control bit positions
  localparam int CB_ON      = 7;
  localparam int CB_CLKGATE = 6;
  localparam int CB_SNDWAKE = 5;
  localparam int CB_DETACH  = 4;
  localparam int CB_UPRES   = 3;
  localparam int CB_PERMIT  = 2;
  localparam int CB_CONFIG  = 1;
  localparam int CB_ADDRV   = 0;

  // usb_global_event_flags / enable bit positions
  localparam int FB_WAKE = 5;
  localparam int FB_EOR  = 4;
  localparam int FB_SOF  = 3;
  localparam int FB_SUSP = 0;
  localparam logic [7:0] FLAG_MASK = 8'h39;
  localparam logic [7:0] IEN_RST   = 8'h10;

  // Endpoint flag bit positions
  localparam int EB_IN    = 0;
  localparam int EB_OUT0  = 1;
  localparam int EB_OUT1  = 2;
  localparam int EB_SETUP = 3;
  localparam int EB_NAKI  = 4;
  localparam int EB_NAKO  = 5;
  localparam int EB_STALL = 6;
  localparam int EP_N     = 7;

  // Upstream resume sequencer
  typedef enum logic [1:0] {
    USBSR_RS_IDLE  = 2'b00,
    USBSR_RS_DRIVE = 2'b01,
    USBSR_RS_DONE  = 2'b10
  } usbsr_rs_t;
endpackage

// File: src/usbsr_top.sv
// USB suspend/resume, detach, interrupt collection and global control with APB slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Suspend detection counts only while controller is on and USB clock runs.
// - Idle bus longer than 3 ms sets suspend flag; interrupt if enabled.
// - Software clearing suspend flag idles the pad; wake-up event releases pad.
// - Resume detection works with clocks gated and CPU asleep.
// - Non-idle bus after suspend sets wake flag, which wakes the CPU if enabled.
// - Clearing suspend flag first takes the controller out of suspend.
// - Clear suspend then set send-wake; hardware shows resume in progress.
// - Resume sent only with permit, clocks running, and 5 ms suspended.
// - Hardware clears resume-active at completion; firmware clears send-wake bit.
// - Detach floats the pull-up reference; clearing it attaches; needs controller on.
// - Interrupt priority is two bits, high and low, 0 lowest to 3 highest.
// - IN done, OUT bank 0/1 and setup flags set on accepted packets.
// - NAK IN and NAK OUT flags set on NAK; only software clears them.
// - Stalled flag sets after STALL sent, resets when SETUP arrives.
// - Clearing controller enable resets controller, transceiver and clock inputs.
// - Configured flag cleared by reset or SE0 of 32 bit times.
// - Address valid clear means address 0; cleared by resets, set by firmware.
// - Clock gate bit stops the 48 MHz input; resume detection stays alive.
// - Suspend, end-of-reset, SOF and wake flags interrupt only when enabled.
module usbsr_top #(
  parameter int SUSPEND_CYC    = usbsr_pkg::SUSPEND_CYC,
  parameter int REMOTE_MIN_CYC = usbsr_pkg::REMOTE_MIN_CYC,
  parameter int RESUME_CYC     = usbsr_pkg::RESUME_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        BUS_IDLE_I,
  input  wire logic        BUS_SE0_I,
  input  wire logic        SOF_I,
  input  wire logic        CLK48_RUN_I,
  input  wire logic        EP_IN_DONE_I,
  input  wire logic        EP_OUT0_I,
  input  wire logic        EP_OUT1_I,
  input  wire logic        EP_SETUP_I,
  input  wire logic        EP_NAK_IN_I,
  input  wire logic        EP_NAK_OUT_I,
  input  wire logic        EP_STALL_SENT_I,
  output logic             USB_IRQ_O,
  output logic      [1:0]  USB_PRIO_O,
  output logic             CPU_WAKE_O,
  output logic             PAD_IDLE_O,
  output logic             USB_CLK_EN_O,
  output logic             CTRL_ON_O,
  output logic             CONFIGURED_O,
  output logic             ADDR_VALID_O,
  output logic             RESUME_DRIVE_O,
  output logic             VREF_O,
  output logic             VREF_OE_O
);

  localparam logic [usbsr_pkg::CNT_W-1:0] SUSP_LIM =
    usbsr_pkg::CNT_W'(SUSPEND_CYC);
  localparam logic [usbsr_pkg::CNT_W-1:0] RMIN_LIM =
    usbsr_pkg::CNT_W'(REMOTE_MIN_CYC);
  localparam logic [usbsr_pkg::CNT_W-1:0] RES_LIM =
    usbsr_pkg::CNT_W'(RESUME_CYC);
  localparam logic [usbsr_pkg::SE0_W-1:0] SE0_LIM =
    usbsr_pkg::SE0_W'(usbsr_pkg::BUS_RESET_CYC);

  typedef struct packed {
    logic                          on;
    logic                          clk_gate;
    logic                          send_wake;
    logic                          detach;
    logic                          permit;
    logic                          configured;
    logic                          addr_valid;
    logic [7:0]                    flags;
    logic [7:0]                    ien;
    logic [1:0]                    prio;
    logic [usbsr_pkg::EP_N-1:0]    epf;
    logic [usbsr_pkg::EP_N-1:0]    epien;
    logic                          pad_idle;
    logic [usbsr_pkg::CNT_W-1:0]   idle_cnt;
    logic [usbsr_pkg::CNT_W-1:0]   susp_cnt;
    logic [usbsr_pkg::SE0_W-1:0]   se0_cnt;
    usbsr_pkg::usbsr_rs_t          rs;
    logic                          resume_drive;
    logic [usbsr_pkg::CNT_W-1:0]   rs_cnt;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic                          irq;
    logic                          cpu_wake;
    logic                          clk_en;
    logic                          vref;
    logic                          vref_oe;
  } usbsr_state_t;

  usbsr_state_t st;
  usbsr_state_t next_st;

  logic        wr;
  logic        clocks_ok;
  logic        wake_evt;
  logic [7:0]  ctrl_rd;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [6:0]  ep_set;
  logic [6:0]  ep_clr;
  logic        mapped;
  logic [7:0]  rd8;

  // Readback view of the global control register
  always_comb begin
    ctrl_rd                        = 8'h00;
    ctrl_rd[usbsr_pkg::CB_ON]      = st.on;
    ctrl_rd[usbsr_pkg::CB_CLKGATE] = st.clk_gate;
    ctrl_rd[usbsr_pkg::CB_SNDWAKE] = st.send_wake;
    ctrl_rd[usbsr_pkg::CB_DETACH]  = st.detach;
    ctrl_rd[usbsr_pkg::CB_UPRES]   = (st.rs == usbsr_pkg::USBSR_RS_DRIVE);
    ctrl_rd[usbsr_pkg::CB_PERMIT]  = st.permit;
    ctrl_rd[usbsr_pkg::CB_CONFIG]  = st.configured;
    ctrl_rd[usbsr_pkg::CB_ADDRV]   = st.addr_valid;
  end

  // Address decode; unmapped reads give zero and an error
  always_comb begin
    mapped = 1'b1;
    case (PADDR_I)
      usbsr_pkg::ADDR_CTRL:  rd8 = ctrl_rd;
      usbsr_pkg::ADDR_FLAGS: rd8 = st.flags;
      usbsr_pkg::ADDR_IEN:   rd8 = st.ien;
      usbsr_pkg::ADDR_PRIO:  rd8 = {6'h00, st.prio};
      usbsr_pkg::ADDR_EPF:   rd8 = {1'b0, st.epf};
      usbsr_pkg::ADDR_EPIEN: rd8 = {1'b0, st.epien};
      default: begin
        rd8    = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // Hardware events, decoded from the bus side
  always_comb begin
    wr        = PSEL_I & PENABLE_I & st.pready & PWRITE_I;
    clocks_ok = st.on & ~st.clk_gate & CLK48_RUN_I;
    // Own resume drive must not count as host wake-up
    wake_evt  = st.on & ~BUS_IDLE_I & (st.flags[usbsr_pkg::FB_SUSP] | st.pad_idle)
                & (st.rs == usbsr_pkg::USBSR_RS_IDLE);
    flag_set  = 8'h00;
    flag_set[usbsr_pkg::FB_SUSP] = clocks_ok & (st.idle_cnt > SUSP_LIM)
                                   & ~st.flags[usbsr_pkg::FB_SUSP];
    flag_set[usbsr_pkg::FB_WAKE] = wake_evt;
    flag_set[usbsr_pkg::FB_SOF]  = clocks_ok & SOF_I;
    flag_set[usbsr_pkg::FB_EOR]  = clocks_ok & ~BUS_SE0_I & (st.se0_cnt >= SE0_LIM);
    ep_set = {EP_STALL_SENT_I, EP_NAK_OUT_I, EP_NAK_IN_I, EP_SETUP_I,
              EP_OUT1_I, EP_OUT0_I, EP_IN_DONE_I} & {7{clocks_ok}};
    // Writing zero clears a flag; writing one leaves it
    flag_clr = (wr && PADDR_I == usbsr_pkg::ADDR_FLAGS) ?
               (~PWDATA_I[7:0] & usbsr_pkg::FLAG_MASK) : 8'h00;
    ep_clr   = (wr && PADDR_I == usbsr_pkg::ADDR_EPF) ? ~PWDATA_I[6:0] : 7'h00;
    // Incoming SETUP withdraws the stall indication
    ep_clr[usbsr_pkg::EB_STALL] = ep_clr[usbsr_pkg::EB_STALL] | EP_SETUP_I;
  end

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;

    // APB: setup phase captures the answer, access phase presents it
    next_st.pready  = PSEL_I & ~PENABLE_I;
    next_st.pslverr = PSEL_I & ~PENABLE_I & ~mapped;
    next_st.prdata  = (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? {24'h000000, rd8} : 32'h00000000;

    // Register writes
    if (wr) begin
      case (PADDR_I)
        usbsr_pkg::ADDR_CTRL: begin
          next_st.on         = PWDATA_I[usbsr_pkg::CB_ON];
          next_st.clk_gate   = PWDATA_I[usbsr_pkg::CB_CLKGATE];
          next_st.send_wake  = PWDATA_I[usbsr_pkg::CB_SNDWAKE];
          next_st.detach     = PWDATA_I[usbsr_pkg::CB_DETACH];
          next_st.permit     = PWDATA_I[usbsr_pkg::CB_PERMIT];
          next_st.configured = PWDATA_I[usbsr_pkg::CB_CONFIG];
          next_st.addr_valid = PWDATA_I[usbsr_pkg::CB_ADDRV];
        end
        usbsr_pkg::ADDR_IEN:   next_st.ien   = PWDATA_I[7:0] & usbsr_pkg::FLAG_MASK;
        usbsr_pkg::ADDR_PRIO:  next_st.prio  = PWDATA_I[1:0];
        usbsr_pkg::ADDR_EPIEN: next_st.epien = PWDATA_I[6:0];
        default: ;
      endcase
    end

    // Sticky flags: a set in the same cycle beats the clear
    next_st.flags = (st.flags & ~flag_clr) | flag_set;
    next_st.epf   = (st.epf & ~ep_clr) | ep_set;

    // Clearing the suspend flag idles the pad and ends suspend
    if (flag_clr[usbsr_pkg::FB_SUSP] & st.flags[usbsr_pkg::FB_SUSP]
        & ~flag_set[usbsr_pkg::FB_SUSP]) begin
      next_st.pad_idle = 1'b1;
    end
    if (wake_evt) begin
      next_st.pad_idle = 1'b0;
    end

    // Suspend timer restarts after each clear so re-detection takes 3 ms
    if (~clocks_ok | ~BUS_IDLE_I | flag_clr[usbsr_pkg::FB_SUSP]) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt <= SUSP_LIM) begin
      next_st.idle_cnt = st.idle_cnt + 1'b1;
    end

    // Time the bus has been idle, for the remote wake rule
    if (~st.on | ~BUS_IDLE_I) begin
      next_st.susp_cnt = '0;
    end else if (st.susp_cnt < RMIN_LIM) begin
      next_st.susp_cnt = st.susp_cnt + 1'b1;
    end

    // Bus reset: SE0 held for 32 full-speed bit times
    if (~st.on | ~BUS_SE0_I) begin
      next_st.se0_cnt = '0;
    end else if (st.se0_cnt < SE0_LIM) begin
      next_st.se0_cnt = st.se0_cnt + 1'b1;
    end
    if (st.on & BUS_SE0_I & (st.se0_cnt >= SE0_LIM)) begin
      next_st.configured = 1'b0;
      next_st.addr_valid = 1'b0;
    end

    // Upstream resume sequencer
    case (st.rs)
      usbsr_pkg::USBSR_RS_IDLE: begin
        next_st.rs_cnt = '0;
        if (st.send_wake & st.permit & clocks_ok & ~st.flags[usbsr_pkg::FB_SUSP]
            & (st.susp_cnt >= RMIN_LIM)) begin
          next_st.rs       = usbsr_pkg::USBSR_RS_DRIVE;
          next_st.pad_idle = 1'b0;
        end
      end
      usbsr_pkg::USBSR_RS_DRIVE: begin
        next_st.rs_cnt = st.rs_cnt + 1'b1;
        if (st.rs_cnt >= RES_LIM - 1'b1) begin
          next_st.rs = usbsr_pkg::USBSR_RS_DONE;
        end
      end
      usbsr_pkg::USBSR_RS_DONE: begin
        // Holds off a second resume until software drops the request
        next_st.rs_cnt = '0;
        if (~st.send_wake) begin
          next_st.rs = usbsr_pkg::USBSR_RS_IDLE;
        end
      end
      default: begin
        next_st.rs     = usbsr_pkg::USBSR_RS_IDLE;
        next_st.rs_cnt = '0;
      end
    endcase

    // Disabled controller: all state is reset except priority, endpoint enables, detach, permit, clock gate and the APB response
    if (~next_st.on) begin
      next_st          = '0;
      next_st.ien      = usbsr_pkg::IEN_RST;
      next_st.prio     = st.prio;
      next_st.epien    = st.epien;
      next_st.detach   = st.detach;
      next_st.permit   = st.permit;
      next_st.clk_gate = st.clk_gate;
      next_st.pready   = PSEL_I & ~PENABLE_I;
      next_st.pslverr  = PSEL_I & ~PENABLE_I & ~mapped;
      next_st.prdata   = (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? {24'h000000, rd8}
                                                            : 32'h00000000;
      if (wr && PADDR_I == usbsr_pkg::ADDR_CTRL) begin
        next_st.detach   = PWDATA_I[usbsr_pkg::CB_DETACH];
        next_st.permit   = PWDATA_I[usbsr_pkg::CB_PERMIT];
        next_st.clk_gate = PWDATA_I[usbsr_pkg::CB_CLKGATE];
      end
      if (wr && PADDR_I == usbsr_pkg::ADDR_PRIO) begin
        next_st.prio = PWDATA_I[1:0];
      end
      if (wr && PADDR_I == usbsr_pkg::ADDR_EPIEN) begin
        next_st.epien = PWDATA_I[6:0];
      end
      if (wr && PADDR_I == usbsr_pkg::ADDR_IEN) begin
        next_st.ien = PWDATA_I[7:0] & usbsr_pkg::FLAG_MASK;
      end
    end

    // Registered outputs, taken from the next state
    next_st.irq      = |(next_st.flags & next_st.ien) |
                       |(next_st.epf & next_st.epien);
    next_st.cpu_wake = next_st.flags[usbsr_pkg::FB_WAKE] &
                       next_st.ien[usbsr_pkg::FB_WAKE];
    next_st.clk_en   = next_st.on & ~next_st.clk_gate;
    next_st.vref     = 1'b1;
    // Own flop so the resume pin is not decoded from the sequencer state
    next_st.resume_drive = (next_st.rs == usbsr_pkg::USBSR_RS_DRIVE);
    // Float only while enabled; a float over 3 us reads as unplugged
    next_st.vref_oe  = ~(next_st.on & next_st.detach);
  end

  // Single state register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st         <= '0;
      st.ien     <= usbsr_pkg::IEN_RST;
      st.vref_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Ports straight from the state register
  assign PRDATA_O       = st.prdata;
  assign PREADY_O       = st.pready;
  assign PSLVERR_O      = st.pslverr;
  assign USB_IRQ_O      = st.irq;
  assign USB_PRIO_O     = st.prio;
  assign CPU_WAKE_O     = st.cpu_wake;
  assign PAD_IDLE_O     = st.pad_idle;
  assign USB_CLK_EN_O   = st.clk_en;
  assign CTRL_ON_O      = st.on;
  assign CONFIGURED_O   = st.configured;
  assign ADDR_VALID_O   = st.addr_valid;
  assign RESUME_DRIVE_O = st.resume_drive;
  assign VREF_O         = st.vref;
  assign VREF_OE_O      = st.vref_oe;

endmodule

`default_nettype wire

// File: test/usbsr_host_model.sv
// Behavioural USB host: line state, bus reset and start-of-frame marks
`timescale 1ns/1ps
`default_nettype none
module usbsr_host_model (
  input  wire logic [1:0] mode_i,
  input  wire logic       sof_req_i,
  input  wire logic       k_drive_i,
  output logic            bus_idle_o,
  output logic            bus_se0_o,
  output logic            sof_o
);
  // Mode 0 idle J, 1 traffic, 2 SE0; device K drive breaks the idle state
  assign bus_idle_o = (mode_i == 2'h0) && !k_drive_i;
  assign bus_se0_o  = (mode_i == 2'h2);
  assign sof_o      = sof_req_i;
endmodule
`default_nettype wire

// File: test/usbsr_top_assertions.sv
// Port-level checker of the USB suspend/resume control block
`timescale 1ns/1ps
`default_nettype none
module usbsr_top_assertions #(
  parameter int REMOTE_MIN_CYC = 40,
  parameter int RESUME_CYC     = 10
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic BUS_IDLE_I,
  input wire logic BUS_SE0_I,
  input wire logic CLK48_RUN_I,
  input wire logic PSLVERR_O,
  input wire logic USB_IRQ_O,
  input wire logic CPU_WAKE_O,
  input wire logic PAD_IDLE_O,
  input wire logic USB_CLK_EN_O,
  input wire logic CTRL_ON_O,
  input wire logic CONFIGURED_O,
  input wire logic ADDR_VALID_O,
  input wire logic RESUME_DRIVE_O,
  input wire logic VREF_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  int drv_cnt;
  int idle_cnt;
  int se0_cnt;
  // Run lengths; idle and SE0 saturate so long idles cannot wrap
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      drv_cnt  <= 0;
      idle_cnt <= 0;
      se0_cnt  <= 0;
    end else begin
      drv_cnt  <= RESUME_DRIVE_O ? drv_cnt + 1 : 0;
      idle_cnt <= BUS_IDLE_I ? idle_cnt + int'(idle_cnt < 1000) : 0;
      se0_cnt  <= BUS_SE0_I ? se0_cnt + int'(se0_cnt < 1000) : 0;
    end
  end
  a_resume_len: assert property ($fell(RESUME_DRIVE_O) |-> drv_cnt == RESUME_CYC)
    else $error("resume drive length wrong");
  a_resume_cond: assert property ($rose(RESUME_DRIVE_O) |-> $past(CLK48_RUN_I)
    && $past(USB_CLK_EN_O) && $past(idle_cnt) >= REMOTE_MIN_CYC - 1)
    else $error("resume drive without its conditions");
  a_wake_irq: assert property (CPU_WAKE_O |-> USB_IRQ_O)
    else $error("cpu wake without interrupt");
  a_wake_pad: assert property ($rose(CPU_WAKE_O) |-> !PAD_IDLE_O)
    else $error("pad still idle after wake");
  a_off_clear: assert property (!CTRL_ON_O && !$past(CTRL_ON_O) |-> !CONFIGURED_O
    && !ADDR_VALID_O && !RESUME_DRIVE_O && !USB_CLK_EN_O)
    else $error("state kept while controller off");
  a_bus_reset: assert property (se0_cnt > usbsr_pkg::BUS_RESET_CYC + 2
    |-> !CONFIGURED_O && !ADDR_VALID_O)
    else $error("bus reset left configuration");
  a_detach_on: assert property (!VREF_OE_O |-> CTRL_ON_O || $past(CTRL_ON_O))
    else $error("pull-up floated while off");
  a_clk_gate: assert property (USB_CLK_EN_O |-> CTRL_ON_O)
    else $error("usb clock on while controller off");
  c_resume: cover property ($rose(RESUME_DRIVE_O));
  c_wake: cover property ($rose(CPU_WAKE_O));
  c_slverr: cover property (PSLVERR_O);
endmodule
bind usbsr_top usbsr_top_assertions #(.REMOTE_MIN_CYC(REMOTE_MIN_CYC), .RESUME_CYC(RESUME_CYC))
  i_usbsr_top_assertions (.CLK_I, .NRST_I, .BUS_IDLE_I, .BUS_SE0_I, .CLK48_RUN_I, .PSLVERR_O,
  .USB_IRQ_O, .CPU_WAKE_O, .PAD_IDLE_O, .USB_CLK_EN_O, .CTRL_ON_O, .CONFIGURED_O,
  .ADDR_VALID_O, .RESUME_DRIVE_O, .VREF_OE_O);
`default_nettype wire

// File: test/usbsr_top_tb_top.sv
// Self-checking bench of the USB suspend/resume control block
`timescale 1ns/1ps
`default_nettype none
module usbsr_top_tb_top;
  localparam int SUS = 20;
  localparam int REM = 40;
  localparam int RES = 10;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run48 = 1'b1;
  logic sofq = 1'b0, idle, se0, sof, prdy, perr, irq, wake, padi, clken, on, cfg;
  logic addrv, drv, vref, vroe, er;
  logic [1:0] mode = 2'h1;
  logic [1:0] prio;
  logic [6:0] ep = 7'h00;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  usbsr_top #(.SUSPEND_CYC(SUS), .REMOTE_MIN_CYC(REM), .RESUME_CYC(RES)) i_usbsr_top (
    .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .BUS_IDLE_I(idle), .BUS_SE0_I(se0), .SOF_I(sof), .CLK48_RUN_I(run48),
    .EP_IN_DONE_I(ep[0]), .EP_OUT0_I(ep[1]), .EP_OUT1_I(ep[2]), .EP_SETUP_I(ep[3]),
    .EP_NAK_IN_I(ep[4]), .EP_NAK_OUT_I(ep[5]), .EP_STALL_SENT_I(ep[6]),
    .USB_IRQ_O(irq), .USB_PRIO_O(prio), .CPU_WAKE_O(wake), .PAD_IDLE_O(padi),
    .USB_CLK_EN_O(clken), .CTRL_ON_O(on), .CONFIGURED_O(cfg), .ADDR_VALID_O(addrv),
    .RESUME_DRIVE_O(drv), .VREF_O(vref), .VREF_OE_O(vroe));
  usbsr_host_model i_usbsr_host_model (.mode_i(mode), .sof_req_i(sofq), .k_drive_i(drv),
    .bus_idle_o(idle), .bus_se0_o(se0), .sof_o(sof));
  always #12.5 clk = ~clk;
  // Hang guard, well above the several hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp32({31'h0, g}, {31'h0, e});
  endtask
  // One APB transfer; the extra edge lets the write's effect reach the ports
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    cmp32(rd, {24'h0, e});
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    ep <= v;
    @(posedge clk);
    ep <= 7'h00;
  endtask
  task automatic t_reset();
    rdchk(usbsr_pkg::ADDR_IEN, 8'h10);
    rdchk(usbsr_pkg::ADDR_CTRL, 8'h00);
    cmp1(vroe, 1'b1);
    cmp1(clken, 1'b0);
    apb(1'b0, 12'h0F0, 32'h0);
    cmp1(er, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(usbsr_pkg::ADDR_PRIO, 8'(i));
      cmp32({30'h0, prio}, 32'(i));
    end
  endtask
  task automatic t_bus_reset();
    wr(usbsr_pkg::ADDR_CTRL, 8'h8B);
    rdchk(usbsr_pkg::ADDR_CTRL, 8'h83);
    cmp1(clken, 1'b1);
    mode <= 2'h2;
    repeat (usbsr_pkg::BUS_RESET_CYC - 20) @(posedge clk);
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    cmp1(cfg, 1'b1);
    mode <= 2'h2;
    repeat (usbsr_pkg::BUS_RESET_CYC + 10) @(posedge clk);
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    cmp1(cfg, 1'b0);
    cmp1(addrv, 1'b0);
    rdchk(usbsr_pkg::ADDR_FLAGS, 8'h10);
    cmp1(irq, 1'b1);
    wr(usbsr_pkg::ADDR_FLAGS, 8'h00);
    cmp1(irq, 1'b0);
  endtask
  task automatic t_suspend();
    wr(usbsr_pkg::ADDR_IEN, 8'h21);
    run48 <= 1'b0;
    mode  <= 2'h0;
    repeat (SUS + 10) @(posedge clk);
    cmp1(irq, 1'b0);
    run48 <= 1'b1;
    repeat (SUS) @(posedge clk);
    cmp1(irq, 1'b0);
    repeat (5) @(posedge clk);
    cmp1(irq, 1'b1);
    rdchk(usbsr_pkg::ADDR_FLAGS, 8'h01);
    wr(usbsr_pkg::ADDR_FLAGS, 8'h00);
    cmp1(padi, 1'b1);
    wr(usbsr_pkg::ADDR_CTRL, 8'hC0);
    cmp1(clken, 1'b0);
    run48 <= 1'b0;
    repeat (SUS + 10) @(posedge clk);
    cmp1(irq, 1'b0);
    mode <= 2'h1;
    repeat (2) @(posedge clk);
    cmp1(wake, 1'b1);
    cmp1(padi, 1'b0);
    run48 <= 1'b1;
    wr(usbsr_pkg::ADDR_CTRL, 8'h80);
    wr(usbsr_pkg::ADDR_FLAGS, 8'h00);
    cmp1(irq, 1'b0);
  endtask
  task automatic t_remote();
    int n;
    wr(usbsr_pkg::ADDR_CTRL, 8'hA0);
    mode <= 2'h0;
    repeat (REM + 20) @(posedge clk);
    cmp1(drv, 1'b0);
    wr(usbsr_pkg::ADDR_FLAGS, 8'h00);
    wr(usbsr_pkg::ADDR_CTRL, 8'hA4);
    n = 0;
    while (drv !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    cmp1(drv, 1'b1);
    rdchk(usbsr_pkg::ADDR_CTRL, 8'hAC);
    n = 0;
    while (drv !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rdchk(usbsr_pkg::ADDR_CTRL, 8'hA4);
    cmp1(wake, 1'b0);
    wr(usbsr_pkg::ADDR_CTRL, 8'h84);
    repeat (REM + 20) @(posedge clk);
    cmp1(drv, 1'b0);
  endtask
  task automatic t_endpoint();
    wr(usbsr_pkg::ADDR_IEN, 8'h00);
    wr(usbsr_pkg::ADDR_EPIEN, 8'h7F);
    for (int i = 0; i < 7; i++) begin
      pulse(7'(1 << i));
      rdchk(usbsr_pkg::ADDR_EPF, 8'((2 << i) - 1));
    end
    cmp1(irq, 1'b1);
    pulse(7'h08);
    rdchk(usbsr_pkg::ADDR_EPF, 8'h3F);
    pulse(7'h48);
    rdchk(usbsr_pkg::ADDR_EPF, 8'h7F);
    wr(usbsr_pkg::ADDR_EPF, 8'h7F);
    rdchk(usbsr_pkg::ADDR_EPF, 8'h7F);
    wr(usbsr_pkg::ADDR_EPF, 8'h00);
    rdchk(usbsr_pkg::ADDR_EPF, 8'h00);
    cmp1(irq, 1'b0);
    wr(usbsr_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clk);
    sofq <= 1'b1;
    @(posedge clk);
    sofq <= 1'b0;
    rdchk(usbsr_pkg::ADDR_FLAGS, 8'h08);
  endtask
  task automatic t_detach();
    wr(usbsr_pkg::ADDR_CTRL, 8'h90);
    cmp1(vroe, 1'b0);
    wr(usbsr_pkg::ADDR_CTRL, 8'h80);
    cmp1(vroe, 1'b1);
    wr(usbsr_pkg::ADDR_CTRL, 8'h13);
    cmp1(vroe, 1'b1);
    cmp1(on, 1'b0);
    cmp1(cfg, 1'b0);
  endtask
  // Main sequence: reset for three cycles, then every scenario in turn
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // First edge after release only launches the outputs; look one edge later
    repeat (2) @(posedge clk);
    cmp1(vref, 1'b1);
    t_reset();
    t_bus_reset();
    t_suspend();
    t_remote();
    t_endpoint();
    t_detach();
    test_done();
  end
endmodule
`default_nettype wire
